/* pstc_map.svh */
/*
 * Offsets-free constant map of the indicator, strap and test control block:
 * timing counts, advertisement masks and default widths.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef PSTC_MAP_SVH
`define PSTC_MAP_SVH

// core clock rate and slow tick
`define PSTC_CLK_MHZ        100
`define PSTC_TICK_US        1000
`define PSTC_TICK_CYCLES    (`PSTC_TICK_US * `PSTC_CLK_MHZ)

// activity load window and flicker half periods, in ticks
`define PSTC_WINDOW_TICKS   100
`define PSTC_HALF_SLOW      80
`define PSTC_HALF_MID       40
`define PSTC_HALF_FAST      20

// qualified events per window that move to a faster flicker
`define PSTC_LOAD_MID       16
`define PSTC_LOAD_HIGH      128

// advertised ability: {100 full, 100 half, 10 full, 10 half}
`define PSTC_ADV_ALL        4'hF
`define PSTC_ADV_TEN        4'h3

// test port widths
`define PSTC_INSTR_W        8
`define PSTC_XOR_W          8

`endif

/* pstc_pkg.sv */
/*
 * Types shared by the indicator, strap and test control block.
 * Assumes nothing of its surroundings.
 */
package pstc_pkg;

    // asynchronous test mode selected by the four test pins
    typedef enum logic [1:0] {
        PSTC_NORMAL,
        PSTC_XOR_TREE,
        PSTC_MFG_TEST
    } pstc_mode_t;

    // activity load class that sets the flicker rate
    typedef enum logic [1:0] {
        PSTC_RATE_SLOW,
        PSTC_RATE_MID,
        PSTC_RATE_FAST
    } pstc_rate_t;

endpackage

/* pstc_act_if.sv */
/*
 * Carrier between the control top and the activity flicker generator.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps

interface pstc_act_if;
    logic tick;       // slow time base, one-cycle pulse
    logic act_event;  // qualified activity this cycle
    logic led_on;     // flicker output, high means lit

    modport ctrl   (output tick, output act_event, input led_on);
    modport pulser (input tick, input act_event, output led_on);
endinterface

/* pstc_act_pulser.sv */
/*
 * Activity flicker generator: measures activity load per window and blinks
 * the activity lamp faster as load grows.
 * Assumes tick and act_event are produced on the same clock.
 */
`timescale 1ns/100ps
`include "pstc_map.svh"

module pstc_act_pulser #(
    parameter int WIN_TICKS = `PSTC_WINDOW_TICKS,
    parameter int LOAD_MID  = `PSTC_LOAD_MID,
    parameter int LOAD_HIGH = `PSTC_LOAD_HIGH
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    pstc_act_if.pulser act
);
    import pstc_pkg::*;

    // classify an event count into a load class
    function automatic pstc_rate_t load_level(input logic [7:0] n);
        if (n >= 8'(LOAD_HIGH))
            return PSTC_RATE_FAST;
        else if (n >= 8'(LOAD_MID))
            return PSTC_RATE_MID;
        return PSTC_RATE_SLOW;
    endfunction

    // half period in ticks for a load class
    function automatic logic [6:0] half_of(input pstc_rate_t r);
        unique case (r)
            PSTC_RATE_FAST: return 7'(`PSTC_HALF_FAST);
            PSTC_RATE_MID:  return 7'(`PSTC_HALF_MID);
            default:        return 7'(`PSTC_HALF_SLOW);
        endcase
    endfunction

    logic [6:0] win_cnt;
    logic [7:0] ev_cnt;
    logic       seen_cur;
    logic       seen_prev;
    pstc_rate_t rate;
    logic       run;
    logic [6:0] phase;
    logic       led;

    wire        win_end = act.tick && (win_cnt == 7'(WIN_TICKS - 1));
    wire        active  = seen_cur || seen_prev || act.act_event;
    wire [6:0]  half    = half_of(rate);
    wire        flip    = run && act.tick && (phase >= half - 7'h01);

    assign act.led_on = led;

    // load window: count events, a new event wins over the window clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            win_cnt   <= 7'h00;
            ev_cnt    <= 8'h00;
            seen_cur  <= 1'h0;
            seen_prev <= 1'h0;
            rate      <= PSTC_RATE_SLOW;
        end else if (win_end) begin
            win_cnt   <= 7'h00;
            ev_cnt    <= {7'h00, act.act_event};
            seen_cur  <= act.act_event;
            seen_prev <= seen_cur || act.act_event;
            rate      <= load_level(ev_cnt);
        end else begin
            win_cnt   <= act.tick ? win_cnt + 7'h01 : win_cnt;
            ev_cnt    <= (act.act_event && ev_cnt != 8'hFF) ? ev_cnt + 8'h01 : ev_cnt;
            seen_cur  <= seen_cur || act.act_event;
        end
    end

    // R2 dark when idle
    // R3 flicker at load rate
    always_ff @(posedge clk) begin
        if (!rst_n || !active) begin
            run   <= 1'h0;
            led   <= 1'h0;
            phase <= 7'h00;
        end else if (!run) begin
            run   <= 1'h1;
            led   <= 1'h1;
            phase <= 7'h00;
        end else if (flip) begin
            led   <= ~led;
            phase <= 7'h00;
        end else if (act.tick) begin
            phase <= phase + 7'h01;
        end
    end

    property p_idle_dark;
        @(posedge clk) disable iff (!rst_n)
        !active |=> !led;
    endproperty
    a_idle_dark: assert property (p_idle_dark) else $error("lamp lit without activity"); // R2

    property p_first_on;
        @(posedge clk) disable iff (!rst_n)
        (active && !run) |=> (led && run);
    endproperty
    a_first_on: assert property (p_first_on) else $error("activity did not light lamp"); // R2

    property p_flicker;
        @(posedge clk) disable iff (!rst_n)
        (flip && active) |=> (led != $past(led)) && (phase == 7'h00);
    endproperty
    a_flicker: assert property (p_flicker) else $error("lamp did not toggle at half period"); // R3

    property p_rate_fast;
        @(posedge clk) disable iff (!rst_n)
        (win_end && ev_cnt >= 8'(LOAD_HIGH)) |=> (half == 7'(`PSTC_HALF_FAST));
    endproperty
    a_rate_fast: assert property (p_rate_fast) else $error("heavy load not at fast rate"); // R3

endmodule // pstc_act_pulser

/* pstc_top.sv */
/*
 * Indicator, strap and test control of a 10/100 twisted-pair PHY: link,
 * activity and speed lamps, ten-only advertisement strap, test mode decode,
 * XOR tree output and manufacturing test port.
 * Assumes status inputs come from PHY logic on REF_CLK; strap and test pins
 * are asynchronous and are synchronised here. Pull-downs are pad cells.
 */
`timescale 1ns/100ps
`include "pstc_map.svh"

// Function
// R1 - link lamp low while link is up
// R2 - activity lamp low on traffic, else off
// R3 - activity lamp flickers faster with load
// R4 - config bit selects wake mode activity source
// R5 - bit zero: broadcast and address match count
// R6 - bit one: address match packets only
// R7 - speed lamp low at 100, off at 10
// R8 - strap high advertises ten megabit only
// R9 - floating strap reads low, advertise all
// R10 - four test pins decode to one mode
// R11 - board drives only listed test combinations
// R12 - test clock and serial input run port
// R13 - execute loads shifted command into instruction
// R14 - test output carries XOR tree or data
// R15 - board holds test enable low for XOR
// R16 - floating test pins read low
// R17 - all pins low keeps normal operation
module pstc_top #(
    parameter int TICK_CYCLES = `PSTC_TICK_CYCLES,
    parameter int INSTR_W     = `PSTC_INSTR_W,
    parameter int XOR_W       = `PSTC_XOR_W
) (
    input  wire logic               REF_CLK,
    input  wire logic               RST_B,
    input  wire logic               LINK_UP,
    input  wire logic               SPEED_100,
    input  wire logic               RX_ACTIVE,
    input  wire logic               TX_ACTIVE,
    input  wire logic               PKT_BROADCAST,
    input  wire logic               PKT_IA_MATCH,
    input  wire logic               WAKE_ON_LAN_MODE,
    input  wire logic               IA_LED_CTRL,
    input  wire logic               ADVERTISE_TEN_ONLY,
    input  wire logic               ISO_TEST_CLOCK,
    input  wire logic               ISO_TEST_SERIAL_IN,
    input  wire logic               ISO_TEST_EXECUTE,
    input  wire logic               TEST_MODE_ENABLE,
    input  wire logic [XOR_W-1:0]   XOR_TREE_IN,
    output logic                    LINK_INDICATOR_N,
    output logic                    ACTIVITY_INDICATOR_N,
    output logic                    SPEED_INDICATOR_N,
    output logic [3:0]              ADV_ABILITY,
    output logic                    TEST_SERIAL_OUT,
    output pstc_pkg::pstc_mode_t    TEST_MODE,
    output logic [INSTR_W-1:0]      TEST_INSTRUCTION
);
    import pstc_pkg::*;

    localparam int TCW = $clog2(TICK_CYCLES);
    localparam int SW  = 5 + XOR_W;

    logic [SW-1:0]      pin_meta;
    logic [SW-1:0]      pin_sync;
    logic               tck_d;
    logic               tex_d;
    logic [INSTR_W-1:0] shift;
    logic [TCW-1:0]     tick_cnt;
    pstc_mode_t         next_mode;
    pstc_act_if         act ();

    // named views of the synchronised pins
    wire                adv_ten_s = pin_sync[0];
    wire                tck_s     = pin_sync[1];
    wire                ti_s      = pin_sync[2];
    wire                tex_s     = pin_sync[3];
    wire                ten_s     = pin_sync[4];
    wire [XOR_W-1:0]    xor_s     = pin_sync[SW-1:5];
    wire                tck_rise  = tck_s && !tck_d;
    wire                tex_rise  = tex_s && !tex_d;
    wire                in_mfg    = (TEST_MODE == PSTC_MFG_TEST);
    wire                xor_val   = ^xor_s;
    wire [INSTR_W-1:0]  next_shift = {shift[INSTR_W-2:0], ti_s};
    wire                tick_end  = (tick_cnt == TCW'(TICK_CYCLES - 1));

    // R10 test mode decode
    // R15 enable high leaves XOR tree
    assign next_mode = ten_s ? PSTC_MFG_TEST :
                       (tck_s && !ti_s && !tex_s) ? PSTC_XOR_TREE : PSTC_NORMAL;

    // R14 test output select
    wire next_test_serial_out = (TEST_MODE == PSTC_XOR_TREE) ? xor_val :
                     in_mfg ? shift[INSTR_W-1] : 1'h0;

    // R4 wake mode activity source
    // R5 broadcast counts when bit clear
    // R6 address match only when set
    wire next_act = WAKE_ON_LAN_MODE ? (PKT_IA_MATCH || (!IA_LED_CTRL && PKT_BROADCAST))
                                     : (RX_ACTIVE || TX_ACTIVE);

    // R16 two-flop synchroniser for pins
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {XOR_TREE_IN, TEST_MODE_ENABLE, ISO_TEST_EXECUTE,
                         ISO_TEST_SERIAL_IN, ISO_TEST_CLOCK, ADVERTISE_TEN_ONLY};
            pin_sync <= pin_meta;
        end
    end

    // R17 mode register, normal out of reset
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            TEST_MODE       <= PSTC_NORMAL;
            TEST_SERIAL_OUT <= 1'h0;
            tck_d           <= 1'h0;
            tex_d           <= 1'h0;
        end else begin
            TEST_MODE       <= next_mode;
            TEST_SERIAL_OUT <= next_test_serial_out;
            tck_d           <= tck_s;
            tex_d           <= tex_s;
        end
    end

    // R12 shift on test clock
    // R13 execute loads instruction
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            shift            <= '0;
            TEST_INSTRUCTION <= '0;
        end else begin
            if (in_mfg && tck_rise)
                shift <= next_shift;
            if (in_mfg && tex_rise)
                TEST_INSTRUCTION <= shift;
        end
    end

    // slow tick divider and activity qualifier
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            tick_cnt      <= '0;
            act.tick      <= 1'h0;
            act.act_event <= 1'h0;
        end else begin
            tick_cnt      <= tick_end ? '0 : tick_cnt + TCW'(1);
            act.tick      <= tick_end;
            act.act_event <= next_act;
        end
    end

    // R1 link lamp
    // R7 speed lamp
    // R8 ten-only advertisement
    // R9 reset and low strap advertise all
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            LINK_INDICATOR_N     <= 1'h1;
            SPEED_INDICATOR_N    <= 1'h1;
            ACTIVITY_INDICATOR_N <= 1'h1;
            ADV_ABILITY          <= `PSTC_ADV_ALL;
        end else begin
            LINK_INDICATOR_N     <= !LINK_UP;
            SPEED_INDICATOR_N    <= !(LINK_UP && SPEED_100);
            ACTIVITY_INDICATOR_N <= !act.led_on;
            ADV_ABILITY          <= adv_ten_s ? `PSTC_ADV_TEN : `PSTC_ADV_ALL;
        end
    end

    // R2 R3 activity flicker generator
    pstc_act_pulser u_pulser (
        .clk   (REF_CLK),
        .rst_n (RST_B),
        .act   (act)
    );

    property p_link;
        @(posedge REF_CLK) disable iff (!RST_B)
        ##1 (LINK_INDICATOR_N == !$past(LINK_UP));
    endproperty
    a_link: assert property (p_link) else $error("link lamp does not follow link"); // R1

    property p_speed;
        @(posedge REF_CLK) disable iff (!RST_B)
        (LINK_UP && !SPEED_100) |=> SPEED_INDICATOR_N;
    endproperty
    a_speed: assert property (p_speed) else $error("speed lamp lit at ten"); // R7

    property p_adv_ten;
        @(posedge REF_CLK) disable iff (!RST_B)
        $rose(ADVERTISE_TEN_ONLY) ##1 ADVERTISE_TEN_ONLY[*3] |=> (ADV_ABILITY == `PSTC_ADV_TEN);
    endproperty
    a_adv_ten: assert property (p_adv_ten) else $error("strap high but all advertised"); // R8

    property p_adv_all;
        @(posedge REF_CLK) disable iff (!RST_B)
        !adv_ten_s |=> (ADV_ABILITY == `PSTC_ADV_ALL);
    endproperty
    a_adv_all: assert property (p_adv_all) else $error("strap low but ten only advertised"); // R9

    property p_wol_ia;
        @(posedge REF_CLK) disable iff (!RST_B)
        (WAKE_ON_LAN_MODE && IA_LED_CTRL && !PKT_IA_MATCH) |=> !act.act_event;
    endproperty
    a_wol_ia: assert property (p_wol_ia) else $error("non-match packet counted"); // R6

    property p_wol_bc;
        @(posedge REF_CLK) disable iff (!RST_B)
        (WAKE_ON_LAN_MODE && !IA_LED_CTRL && PKT_BROADCAST) |=> act.act_event;
    endproperty
    a_wol_bc: assert property (p_wol_bc) else $error("broadcast not counted"); // R5

    property p_xor_mode;
        @(posedge REF_CLK) disable iff (!RST_B)
        (tck_s && !ti_s && !tex_s && !ten_s) |=> (TEST_MODE == PSTC_XOR_TREE);
    endproperty
    a_xor_mode: assert property (p_xor_mode) else $error("XOR tree not decoded"); // R10

    property p_xor_out;
        @(posedge REF_CLK) disable iff (!RST_B)
        (TEST_MODE == PSTC_XOR_TREE) |=> (TEST_SERIAL_OUT == $past(xor_val));
    endproperty
    a_xor_out: assert property (p_xor_out) else $error("XOR result not on test output"); // R14

    property p_shift;
        @(posedge REF_CLK) disable iff (!RST_B)
        (in_mfg && tck_rise) |=> (shift == $past(next_shift));
    endproperty
    a_shift: assert property (p_shift) else $error("serial bit not shifted"); // R12

    property p_exec;
        @(posedge REF_CLK) disable iff (!RST_B)
        (in_mfg && tex_rise) |=> (TEST_INSTRUCTION == $past(shift));
    endproperty
    a_exec: assert property (p_exec) else $error("command not loaded on execute"); // R13

    property p_idle;
        @(posedge REF_CLK) disable iff (!RST_B)
        (pin_sync[4:1] == 4'h0)[*2] |=> (TEST_MODE == PSTC_NORMAL) && !TEST_SERIAL_OUT;
    endproperty
    a_idle: assert property (p_idle) else $error("low test pins left normal mode"); // R17

endmodule // pstc_top

/* pstc_board.sv */
/*
 * Board model around the control block: strap and test pins with pad
 * pull-downs, and a board that only applies the listed test combinations.
 * Assumes the bench gives requested levels and open flags on the core clock.
 */
`timescale 1ns/100ps

module pstc_board (
    input  wire logic       clk,
    input  wire logic [4:0] drv,    // requested {ten, tex, ti, tck, strap}
    input  wire logic [4:0] flt,    // high leaves that pin open
    output logic            strap,
    output logic            tck,
    output logic            ti,
    output logic            tex,
    output logic            ten
);
    logic [4:0] lvl;
    logic [4:0] pin;
    logic       legal;

    assign lvl = drv & ~flt;
    assign legal = lvl[4] | (lvl[3:2] == 2'h0);

    // board applies a legal request on the next edge, else keeps pins
    always_ff @(posedge clk) begin
        if (legal) pin <= lvl;
    end

    // pin fan-out
    assign {ten, tex, ti, tck, strap} = pin;
endmodule // pstc_board

/* pstc_top_tb.sv */
/*
 * Self-checking bench of the indicator, strap and test control block.
 * Assumes the board model for strap and test pins; status inputs are
 * driven one ns after each rising edge of the 100 MHz core clock.
 */
`timescale 1ns/100ps
`include "pstc_map.svh"

module pstc_top_tb;
    import pstc_pkg::*;
    localparam int TK = 10;
    logic       ref_clk, rst_b, link_up, speed_100, wake_on_lan_mode, ia_ctrl;
    logic [3:0] ev;                   // {ia match, broadcast, tx, rx}
    logic [7:0] xin, instr, cmd;
    logic [4:0] drv, flt;
    logic       strap, tck, ti, tex, ten;
    logic       link_n, act_n, spd_n, test_serial_out;
    logic [3:0] adv;
    pstc_mode_t mode;
    int         err_count, checks_done, len;
    pstc_mode_t mode_tab [4] = '{PSTC_XOR_TREE, PSTC_MFG_TEST, PSTC_MFG_TEST, PSTC_NORMAL};
    logic [3:0] pin_tab [4] = '{4'h1, 4'h8, 4'hF, 4'h0};
    logic [7:0] xor_tab [5] = '{8'h00, 8'h01, 8'h5A, 8'h80, 8'hFE};

    // core clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    pstc_board pstc_board_i (.clk(ref_clk), .drv(drv), .flt(flt), .strap(strap), .tck(tck), .ti(ti),
        .tex(tex), .ten(ten));

    pstc_top #(.TICK_CYCLES(TK)) pstc_top_i (.REF_CLK(ref_clk), .RST_B(rst_b), .LINK_UP(link_up),
        .SPEED_100(speed_100), .RX_ACTIVE(ev[0]), .TX_ACTIVE(ev[1]), .PKT_BROADCAST(ev[2]),
        .PKT_IA_MATCH(ev[3]), .WAKE_ON_LAN_MODE(wake_on_lan_mode), .IA_LED_CTRL(ia_ctrl), .ADVERTISE_TEN_ONLY(strap),
        .ISO_TEST_CLOCK(tck), .ISO_TEST_SERIAL_IN(ti), .ISO_TEST_EXECUTE(tex), .TEST_MODE_ENABLE(ten),
        .XOR_TREE_IN(xin), .LINK_INDICATOR_N(link_n), .ACTIVITY_INDICATOR_N(act_n),
        .SPEED_INDICATOR_N(spd_n), .ADV_ABILITY(adv), .TEST_SERIAL_OUT(test_serial_out), .TEST_MODE(mode),
        .TEST_INSTRUCTION(instr));

    // verdict and end of run
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    // compare tasks, one per result kind
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_mode(input pstc_mode_t got, input pstc_mode_t exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle event, lamp looked at three cycles after it
    task automatic pulse(input logic [3:0] e, input logic exp);
        ev = e;
        cyc(1);
        ev = 4'h0;
        cyc(3);
        chk_bit(act_n, exp);
    endtask

    // bounded wait until the lamp stays dark longer than any flicker off phase
    task automatic wait_off;
        int n;
        int quiet;
        n = 0;
        quiet = 0;
        while (quiet <= (`PSTC_HALF_SLOW + 5) * TK && n < 5000) begin
            cyc(1);
            n++;
            quiet = (act_n === 1'b1) ? quiet + 1 : 0;
        end
        chk_bit(act_n, 1'b1);
        chk_bit(quiet > (`PSTC_HALF_SLOW + 5) * TK, 1'b1);
        if (quiet <= (`PSTC_HALF_SLOW + 5) * TK) summarize();
    endtask

    // tx events every gap cycles; len is the last full lamp phase
    task automatic run_load(input int gap, input int ncyc, output int ln);
        int   last;
        logic prev;
        last = 0;
        ln = 0;
        prev = act_n;
        for (int i = 0; i < ncyc; i++) begin
            ev[1] = (i % gap == 0);
            cyc(1);
            if (act_n !== prev) begin
                ln = i - last;
                last = i;
                prev = act_n;
            end
        end
        ev = 4'h0;
    endtask

    task automatic setpins(input logic [3:0] p);
        drv[4:1] = p;
        flt[4:1] = 4'h0;
        cyc(5);
    endtask

    // main sequence
    initial begin
        err_count = 0;
        checks_done = 0;
        {rst_b, link_up, speed_100, wake_on_lan_mode, ia_ctrl} = 5'h00;
        ev = 4'h0;
        xin = 8'h00;
        drv = 5'h00;
        flt = 5'h1F;
        cmd = 8'hA6;
        cyc(6);
        rst_b = 1'b1;
        cyc(1);
        chk_bit(link_n, 1'b1);
        chk_bit(spd_n, 1'b1);
        chk_bit(act_n, 1'b1);
        chk_bit(test_serial_out, 1'b0);
        chk_vec({4'h0, adv}, {4'h0, `PSTC_ADV_ALL});
        chk_mode(mode, PSTC_NORMAL);
        chk_vec(instr, 8'h00);
        link_up = 1'b1;
        cyc(2);
        chk_bit(link_n, 1'b0);
        speed_100 = 1'b1;
        cyc(2);
        chk_bit(spd_n, 1'b0);
        speed_100 = 1'b0;
        cyc(2);
        chk_bit(spd_n, 1'b1);
        link_up = 1'b0;
        cyc(2);
        chk_bit(link_n, 1'b1);
        drv[0] = 1'b1;
        flt[0] = 1'b0;
        cyc(5);
        chk_vec({4'h0, adv}, {4'h0, `PSTC_ADV_TEN});
        drv[0] = 1'b0;
        cyc(5);
        chk_vec({4'h0, adv}, {4'h0, `PSTC_ADV_ALL});
        pulse(4'h1, 1'b0);
        run_load(2, 4000, len);
        chk_bit(len >= (`PSTC_HALF_FAST - 1) * TK && len <= (`PSTC_HALF_FAST + 1) * TK, 1'b1);
        run_load(200, 5000, len);
        chk_bit(len >= (`PSTC_HALF_SLOW - 1) * TK && len <= (`PSTC_HALF_SLOW + 1) * TK, 1'b1);
        wait_off();
        wake_on_lan_mode = 1'b1;
        pulse(4'h1, 1'b1);
        pulse(4'h4, 1'b0);
        wait_off();
        ia_ctrl = 1'b1;
        pulse(4'h4, 1'b1);
        pulse(4'h8, 1'b0);
        wait_off();
        for (int i = 0; i < 4; i++) begin
            setpins(pin_tab[i]);
            chk_mode(mode, mode_tab[i]);
        end
        chk_bit(test_serial_out, 1'b0);
        setpins(4'h1);
        foreach (xor_tab[i]) begin
            xin = xor_tab[i];
            cyc(5);
            chk_bit(test_serial_out, ^xor_tab[i]);
        end
        setpins(4'h0);
        setpins(4'h8);
        for (int i = 7; i >= 0; i--) begin
            drv[2] = cmd[i];
            cyc(4);
            drv[1] = 1'b1;
            cyc(4);
            drv[1] = 1'b0;
            cyc(4);
        end
        chk_bit(test_serial_out, cmd[7]);
        chk_vec(instr, 8'h00);
        drv[3] = 1'b1;
        cyc(4);
        drv[3] = 1'b0;
        cyc(4);
        chk_vec(instr, cmd);
        summarize();
    end
endmodule // pstc_top_tb
